// ### hw/bcel_channel.sv
// one buffer channel: configuration bytes, access gate and bank rotation
`timescale 1ns/1ps
module bcel_channel
  import bcel_pkg::*;
#(
  parameter int CH_IDX = 0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // granted access
  input  wire logic         acc_valid,
  input  wire logic         acc_master,
  input  wire bcel_req_type acc,
  input  wire logic         ack_by_write,
  // frame boundary
  input  wire logic         frame_end,
  input  wire logic         fcs_ok,
  // results
  output wire logic         cfg_hit,
  output logic [7:0]        cfg_rdata,
  output wire logic         buf_hit,
  output wire logic         buf_ok,
  output wire logic [15:0]  bank_add,
  output wire logic         host_evt_set,
  output wire logic         mst_evt_set,
  output wire logic         host_evt_clr,
  output wire logic         mst_evt_clr,
  output wire logic         act_written
);
  localparam logic [12:0] CFG_ROW = 13'((BCEL_CH_BASE >> 3) + CH_IDX);

  logic [15:0] start;
  logic [15:0] len;
  logic [7:0]  ctrl;
  logic        act, full, fresh, m_open, h_open, m_end_seen;
  logic        m_pend, m_pend_prod;
  logic [1:0]  wbuf, rbuf, latest;

  // address decode of the buffer window
  wire logic [16:0] stop = {1'b0, start} + {1'b0, len};
  wire logic mbx    = ctrl[BCEL_CTRL_MBX];
  wire logic prod   = acc_master == ctrl[BCEL_CTRL_MWR];
  wire logic in_buf = act && len != 16'h0000 && acc.addr >= start &&
                      {1'b0, acc.addr} < stop;
  wire logic is_start = acc.addr == start;
  wire logic is_end   = {1'b0, acc.addr} == stop - 17'h00001;
  wire logic side_open = acc_master ? m_open : h_open;
  wire logic perm = !mbx || (prod ? !full : full);
  wire logic end_blk = acc_master && is_end && m_end_seen;
  wire logic allow = in_buf && perm && (is_start || side_open)
                     && !end_blk;
  // a host consumer with write acknowledge closes on the write only
  wire logic end_counts = acc_master || prod || !ack_by_write
                          || acc.wr;
  wire logic live = acc_valid && !frame_end && allow;
  wire logic opening = live && is_start;
  wire logic swap = opening && !prod && !mbx && fresh;
  wire logic fin = live && is_end && end_counts;
  wire logic host_fin = fin && !acc_master;
  wire logic master_fin = fin && acc_master;
  wire logic commit_m = frame_end && m_pend && fcs_ok;
  wire logic do_done = commit_m || host_fin;
  wire logic done_prod = commit_m ? m_pend_prod : prod;
  wire logic [1:0] bank = mbx ? 2'h0 : (prod ? wbuf : (swap ? latest : rbuf));
  wire logic cfg_wr = acc_valid && acc_master && acc.wr && cfg_hit;

  assign cfg_hit = acc.addr[15:3] == CFG_ROW;
  assign buf_hit = in_buf;
  assign buf_ok = allow && (prod || !acc.wr);
  assign bank_add = bank == 2'h2 ? {len[14:0], 1'b0} :
                    (bank == 2'h1 ? len : 16'h0000);
  assign host_evt_set = commit_m;
  assign mst_evt_set  = host_fin;
  assign host_evt_clr = opening && !acc_master;
  assign mst_evt_clr  = opening && acc_master;
  assign act_written  = cfg_wr && acc.addr[2:0] == BCEL_CH_ACT;

  // configuration read-back; status shows which side owns the buffer
  always_comb begin
    case (acc.addr[2:0])
      BCEL_CH_START_LO: cfg_rdata = start[7:0];
      BCEL_CH_START_HI: cfg_rdata = start[15:8];
      BCEL_CH_LEN_LO:   cfg_rdata = len[7:0];
      BCEL_CH_LEN_HI:   cfg_rdata = len[15:8];
      BCEL_CH_CTRL:     cfg_rdata = ctrl;
      BCEL_CH_STAT:     cfg_rdata = {2'h0, rbuf, full, fresh,
                                     m_open, h_open};
      BCEL_CH_ACT:      cfg_rdata = {7'h00, act};
      default:          cfg_rdata = 8'h00;
    endcase
  end

  // configuration bytes, written by the fieldbus side only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      start <= BCEL_RST_HALF;
      len   <= BCEL_RST_HALF;
      ctrl  <= BCEL_RST_BYTE;
      act   <= 1'b0;
    end else if (cfg_wr) begin
      case (acc.addr[2:0])
        BCEL_CH_START_LO: start[7:0]  <= acc.wdata;
        BCEL_CH_START_HI: start[15:8] <= acc.wdata;
        BCEL_CH_LEN_LO:   len[7:0]    <= acc.wdata;
        BCEL_CH_LEN_HI:   len[15:8]   <= acc.wdata;
        BCEL_CH_CTRL:     ctrl        <= acc.wdata;
        BCEL_CH_ACT:      act         <= acc.wdata[0];
        default: ;
      endcase
    end
  end

  // per-side open state; fieldbus changes wait for the frame check
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      m_open      <= 1'b0;
      m_end_seen  <= 1'b0;
      m_pend      <= 1'b0;
      m_pend_prod <= 1'b0;
      h_open      <= 1'b0;
    end else begin
      if (frame_end) begin
        m_open     <= 1'b0;
        m_end_seen <= 1'b0;
        m_pend     <= 1'b0;
      end else if (master_fin) begin
        m_open      <= 1'b0;
        m_end_seen  <= 1'b1;
        m_pend      <= 1'b1;
        m_pend_prod <= prod;
      end else if (opening && acc_master) begin
        m_open <= 1'b1;
      end
      if (host_fin || !act) h_open <= 1'b0;
      else if (opening && !acc_master) h_open <= 1'b1;
    end
  end

  // ownership and producer bank rotation on completed accesses, consumer bank swap on opening
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      full   <= 1'b0;
      fresh  <= 1'b0;
      wbuf   <= 2'h0;
      rbuf   <= 2'h1;
      latest <= 2'h1;
    end else if (!act) begin
      full  <= 1'b0;
      fresh <= 1'b0;
    end else if (do_done && mbx) begin
      full <= done_prod;
    end else if (do_done && done_prod) begin
      latest <= wbuf;
      wbuf   <= 2'h3 - rbuf - wbuf;
      fresh  <= 1'b1;
    end else if (swap) begin
      rbuf  <= latest;
      fresh <= 1'b0;
    end
  end

endmodule : bcel_channel

// ### hw/bcel_fifo.sv
// request FIFO with registered full and empty flags
`timescale 1ns/1ps
module bcel_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire logic        push = in_valid && in_ready;
  wire logic        pop  = out_valid && out_ready;
  wire logic [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data = mem[rd_ptr];

  // storage has no reset, only the pointers, count and flags do
  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  // flags registered so ready and valid leave straight from flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= wr_ptr + AW'(push);
      rd_ptr    <= rd_ptr + AW'(pop);
      count     <= next_count;
      in_ready  <= next_count != FULL_CNT;
      out_valid <= next_count != '0;
    end
  end

endmodule : bcel_fifo

// ### hw/bcel_pkg.sv
// shared constants and types of the buffer channel and event block
package bcel_pkg;

  // register offsets in the byte address space
  localparam logic [15:0] BCEL_OFF_HOST_INFO = 16'h014E;
  localparam logic [15:0] BCEL_OFF_SYNC_CFG  = 16'h0151;
  localparam logic [15:0] BCEL_OFF_MST_MASK  = 16'h0200;
  localparam logic [15:0] BCEL_OFF_HOST_MASK = 16'h0204;
  localparam logic [15:0] BCEL_OFF_MST_REQ   = 16'h0210;
  localparam logic [15:0] BCEL_OFF_HOST_REQ  = 16'h0220;
  localparam logic [15:0] BCEL_CH_BASE       = 16'h0800;
  localparam logic [15:0] BCEL_CH0_ACT       = 16'h0806;
  localparam logic [15:0] BCEL_RAM_BASE      = 16'h1000;

  // byte offsets inside one 8-byte channel record
  localparam logic [2:0] BCEL_CH_START_LO = 3'h0;
  localparam logic [2:0] BCEL_CH_START_HI = 3'h1;
  localparam logic [2:0] BCEL_CH_LEN_LO   = 3'h2;
  localparam logic [2:0] BCEL_CH_LEN_HI   = 3'h3;
  localparam logic [2:0] BCEL_CH_CTRL     = 3'h4;
  localparam logic [2:0] BCEL_CH_STAT     = 3'h5;
  localparam logic [2:0] BCEL_CH_ACT      = 3'h6;

  // field positions
  localparam int BCEL_CTRL_MBX      = 1;
  localparam int BCEL_CTRL_MWR      = 2;
  localparam int BCEL_CFG_IRQ_OD    = 0;
  localparam int BCEL_CFG_IRQ_POL   = 1;
  localparam int BCEL_CFG_PLS0_MAP  = 3;
  localparam int BCEL_CFG_PLS1_MAP  = 7;
  localparam int BCEL_EV_PLS0       = 2;
  localparam int BCEL_EV_PLS1       = 3;
  localparam int BCEL_EV_ACT        = 4;
  localparam int BCEL_EV_CH_LSB     = 8;

  // values after reset
  localparam logic [7:0]  BCEL_RST_BYTE = 8'h00;
  localparam logic [15:0] BCEL_RST_HALF = 16'h0000;
  localparam logic [31:0] BCEL_RST_WORD = 32'h0000_0000;

  // one byte access from either side
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bcel_req_type;

endpackage : bcel_pkg

// ### hw/bcel_top.sv
// buffer channels, shared process memory and event request logic
//
// Notes on behaviour
// - buffer access is denied unless it starts at the buffer's first address.
// - once opened, the whole buffer is open, in one pass or several.
// - access to the last address closes the buffer and raises its event.
// - a second fieldbus last-address access within one frame is refused.
// - buffered mode hands the consumer the newest complete producer buffer.
// - mailbox mode blocks producer until consumer read, then blocks consumer.
// - direction and mode are chosen per channel by the fieldbus side.
// - fieldbus buffer changes commit at frame end only with good checksum.
// - channel configuration records start at byte address 0x0800.
// - host interrupt is OR of host request AND host mask.
// - sync/latch host config register sets the interrupt pin's driver.
// - config bits 3 and 7 map sync pulses into the host request.
// - outgoing IRQ field is incoming field OR fieldbus request AND mask.
// - with write acknowledge, host closes a read buffer by writing its end.
// - with write acknowledge, host write to 0x0806 clears request bit 4.
`timescale 1ns/1ps
module bcel_top
  import bcel_pkg::*;
#(
  parameter int NUM_CH       = 8,
  parameter int RAM_BYTES    = 4096,
  parameter int FIFO_DEPTH   = 8,
  parameter bit ACK_BY_WRITE = 1'b0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // fieldbus frame path
  input  wire logic         mst_valid,
  input  wire bcel_req_type mst_req,
  input  wire logic         frame_end,
  input  wire logic         fcs_ok,
  output logic              mst_rvalid,
  output logic [7:0]        mst_rdata,
  output logic              mst_denied,
  input  wire logic [15:0]  mst_irq_in,
  output logic [15:0]       mst_irq_out,
  // local host port
  input  wire logic         hst_valid,
  output wire logic         hst_ready,
  input  wire bcel_req_type hst_req,
  output logic              hst_rvalid,
  output logic [7:0]        hst_rdata,
  output logic              hst_denied,
  // distributed clock pulses
  input  wire logic         sync_pulse_zero,
  input  wire logic         sync_pulse_one,
  // host interrupt pin
  output logic              irq_out,
  output logic              irq_oe_n
);
  // sizes
  localparam int RAW = $clog2(RAM_BYTES);
  localparam int QW  = $bits(bcel_req_type);

  // host requests queue here while the fieldbus side holds the memory
  bcel_req_type fifo_req;
  logic         fifo_valid;
  wire logic    h_go = fifo_valid && !mst_valid && !frame_end;

  bcel_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (hst_valid),
    .in_ready  (hst_ready),
    .in_data   (hst_req),
    .out_valid (fifo_valid),
    .out_ready (h_go),
    .out_data  (fifo_req)
  );

  // one access per cycle, fieldbus first; frame end takes the cycle
  wire logic         acc_master = mst_valid;
  wire bcel_req_type acc = mst_valid ? mst_req : fifo_req;

  // one access goes on
  wire logic         acc_valid = (mst_valid && !frame_end) || h_go;
  wire logic [15:0]  a = acc.addr;

  // host strobes
  wire logic         host_acc = h_go;
  wire logic         host_wr = host_acc && acc.wr;
  wire logic         host_rd = host_acc && !acc.wr;

  // channel results, one per channel
  logic [NUM_CH-1:0] ch_cfg_hit, ch_buf_hit, ch_buf_ok, ch_act;
  logic [NUM_CH-1:0] ch_hset, ch_mset, ch_hclr, ch_mclr;
  logic [7:0]        ch_rdata [NUM_CH];
  logic [15:0]       ch_bank [NUM_CH];

  // instances
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    bcel_channel #(
      .CH_IDX (g)
    ) u_ch (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .acc_valid    (acc_valid),
      .acc_master   (acc_master),
      .acc          (acc),
      .ack_by_write (ACK_BY_WRITE),
      .frame_end    (frame_end),
      .fcs_ok       (fcs_ok),
      .cfg_hit      (ch_cfg_hit[g]),
      .cfg_rdata    (ch_rdata[g]),
      .buf_hit      (ch_buf_hit[g]),
      .buf_ok       (ch_buf_ok[g]),
      .bank_add     (ch_bank[g]),
      .host_evt_set (ch_hset[g]),
      .mst_evt_set  (ch_mset[g]),
      .host_evt_clr (ch_hclr[g]),
      .mst_evt_clr  (ch_mclr[g]),
      .act_written  (ch_act[g])
    );
  end

  // merge channel answers; buffer windows are assumed not to overlap
  logic [7:0]  cfg_rdata;
  logic [15:0] bank_add;
  always_comb begin
    cfg_rdata = 8'h00;
    bank_add  = 16'h0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_cfg_hit[i]) cfg_rdata = cfg_rdata | ch_rdata[i];
      if (ch_buf_hit[i]) bank_add = bank_add | ch_bank[i];
    end
  end

  // event registers and configuration
  logic [15:0] mst_mask;
  logic [31:0] host_mask;

  // requests
  logic [15:0] mst_evt;
  logic [31:0] host_evt;
  logic [7:0]  sync_cfg;

  // register decode by word, byte lane from the low address bits
  wire logic hit_info  = a == BCEL_OFF_HOST_INFO;
  wire logic hit_scfg  = a == BCEL_OFF_SYNC_CFG;
  wire logic hit_mmask = a[15:1] == BCEL_OFF_MST_MASK[15:1];
  wire logic hit_hmask = a[15:2] == BCEL_OFF_HOST_MASK[15:2];
  wire logic hit_mreq  = a[15:1] == BCEL_OFF_MST_REQ[15:1];
  wire logic hit_hreq  = a[15:2] == BCEL_OFF_HOST_REQ[15:2];

  // channel records
  wire logic any_cfg   = |ch_cfg_hit;
  wire logic reg_hit   = hit_info || hit_scfg || hit_mmask ||
                         hit_hmask || hit_mreq || hit_hreq || any_cfg;

  // lane shift
  wire logic [4:0] sh  = {a[1:0], 3'h0};

  wire logic [7:0] reg_rdata =
    hit_info  ? {7'h00, ACK_BY_WRITE} :
    hit_scfg  ? sync_cfg :
    hit_mmask ? 8'(mst_mask >> {a[0], 3'h0}) :
    hit_hmask ? 8'(host_mask >> sh) :
    hit_mreq  ? 8'(mst_evt >> {a[0], 3'h0}) :
    hit_hreq  ? 8'(host_evt >> sh) :
    any_cfg   ? cfg_rdata : 8'h00;

  // process memory: buffer windows are steered to their current bank
  logic [7:0] ram [RAM_BYTES];

  // window and gate
  wire logic ram_hit = a >= BCEL_RAM_BASE &&
                       {1'b0, a} < {1'b0, BCEL_RAM_BASE} + 17'(RAM_BYTES);

  // gating
  wire logic any_buf = |ch_buf_hit;
  wire logic ram_ok  = ram_hit && (!any_buf || |ch_buf_ok);
  wire logic [15:0] ram_off = a - BCEL_RAM_BASE + bank_add;
  wire logic [RAW-1:0] ram_idx = ram_off[RAW-1:0];

  // read mux
  wire logic acc_ok = reg_hit || ram_ok;
  wire logic [7:0] rd_byte = ram_ok ? ram[ram_idx] : reg_rdata;
  // zero on write
  wire logic rd_ok = acc_ok && !acc.wr && !frame_end;

  // write port, no reset
  always_ff @(posedge sys_clk) begin
    if (acc_valid && acc.wr && ram_ok) ram[ram_idx] <= acc.wdata;
  end

  // register writes: masks and config from their owning side
  wire logic mst_wr = mst_valid && !frame_end && acc.wr;

  // mask and config flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mst_mask  <= BCEL_RST_HALF;
      host_mask <= BCEL_RST_WORD;
      sync_cfg  <= BCEL_RST_BYTE;
    end else begin
      if (mst_wr && hit_mmask) mst_mask[{a[0], 3'h0} +: 8] <= acc.wdata;
      if (host_wr && hit_hmask) host_mask[sh +: 8] <= acc.wdata;
      if (host_wr && hit_scfg) sync_cfg <= acc.wdata;
    end
  end

  // reading the request word clears the mapped sync bits
  wire logic rd_hreq = host_rd && hit_hreq && a[1:0] == 2'h0;
  wire logic act_rd  = host_rd && any_cfg && a[2:0] == BCEL_CH_ACT;
  wire logic act_ack = ACK_BY_WRITE ? (host_wr && a == BCEL_CH0_ACT)
                                    : act_rd;

  // strobes
  logic [31:0] h_set, h_clr;
  logic [15:0] m_set, m_clr;
  always_comb begin
    h_set = BCEL_RST_WORD;
    h_clr = BCEL_RST_WORD;
    m_set = BCEL_RST_HALF;
    m_clr = BCEL_RST_HALF;

    // channel completions
    h_set[BCEL_EV_CH_LSB +: NUM_CH] = ch_hset;
    h_clr[BCEL_EV_CH_LSB +: NUM_CH] = ch_hclr;
    m_set[BCEL_EV_CH_LSB +: NUM_CH] = ch_mset;
    m_clr[BCEL_EV_CH_LSB +: NUM_CH] = ch_mclr;

    // mapped pulses
    h_set[BCEL_EV_PLS0] = sync_pulse_zero &&
                          sync_cfg[BCEL_CFG_PLS0_MAP];
    h_set[BCEL_EV_PLS1] = sync_pulse_one &&
                          sync_cfg[BCEL_CFG_PLS1_MAP];
    h_clr[BCEL_EV_PLS0] = rd_hreq;
    h_clr[BCEL_EV_PLS1] = rd_hreq;

    // activation
    h_set[BCEL_EV_ACT]   = |ch_act;
    h_clr[BCEL_EV_ACT]   = act_ack;
  end

  // sticky requests; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      host_evt <= BCEL_RST_WORD;
      mst_evt  <= BCEL_RST_HALF;
    end else begin
      host_evt <= (host_evt & ~h_clr) | h_set;
      mst_evt  <= (mst_evt & ~m_clr) | m_set;
    end
  end

  // interrupt pin: push-pull follows polarity, open drain only pulls
  wire logic irq_act = |(host_evt & host_mask);
  wire logic pol = sync_cfg[BCEL_CFG_IRQ_POL];

  // pin flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
    end else if (sync_cfg[BCEL_CFG_IRQ_OD]) begin
      irq_out  <= pol;
      irq_oe_n <= !irq_act;
    end else begin
      irq_out  <= pol ? irq_act : !irq_act;
      irq_oe_n <= 1'b0;
    end
  end

  // outgoing IRQ field of the passing datagram
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) mst_irq_out <= BCEL_RST_HALF;
    else mst_irq_out <= mst_irq_in | (mst_evt & mst_mask);
  end

  // answers: one cycle after the access, zero data when refused
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mst_rvalid <= 1'b0;
      mst_rdata  <= BCEL_RST_BYTE;
      mst_denied <= 1'b0;
      hst_rvalid <= 1'b0;
      hst_rdata  <= BCEL_RST_BYTE;
      hst_denied <= 1'b0;
    end else begin
      mst_rvalid <= mst_valid;
      mst_rdata  <= (mst_valid && rd_ok) ? rd_byte : 8'h00;
      mst_denied <= mst_valid && (frame_end || !acc_ok);

      // host side
      hst_rvalid <= h_go;
      hst_rdata  <= (h_go && rd_ok) ? rd_byte : 8'h00;
      hst_denied <= h_go && !acc_ok;
    end
  end

endmodule : bcel_top

// ### sim/bcel_host_model.sv
// local host model: queued byte requests held until the FIFO takes them
`timescale 1ns/1ps
module bcel_host_model
  import bcel_pkg::*;
(
  // clock
  input  wire logic    sys_clk,
  // host port
  input  wire logic    hst_ready,
  output logic         hst_valid,
  output bcel_req_type hst_req
);
  bcel_req_type q[$];
  logic         taken = 1'h0;
  initial hst_valid = 1'h0;
  initial hst_req = '0;
  // handshake sampled on the rising edge
  always @(posedge sys_clk) taken <= hst_valid && hst_ready;
  // one access per request, so reads and clears never share one
  // idle lines toggle rather than hold a stale request
  always @(negedge sys_clk) begin
    if (taken || !hst_valid) begin
      hst_valid <= q.size() > 0;
      hst_req   <= q.size() > 0 ? q[0] : ~hst_req;
      if (q.size() > 0) void'(q.pop_front());
    end
  end
endmodule : bcel_host_model

// ### sim/bcel_top_asserts.sv
// port checks for the buffer channel and event block
`timescale 1ns/1ps
module bcel_top_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // fieldbus side
  input wire logic        mst_valid,
  input wire logic        frame_end,
  input wire logic        mst_rvalid,
  input wire logic [7:0]  mst_rdata,
  input wire logic        mst_denied,
  input wire logic [15:0] mst_irq_in,
  input wire logic [15:0] mst_irq_out,
  // host side
  input wire logic        hst_rvalid,
  input wire logic [7:0]  hst_rdata,
  input wire logic        hst_denied
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // an access the fieldbus side may make outside the frame end cycle
  sequence s_take;
    mst_valid && !frame_end;
  endsequence
  a_mst_answer: assert property (s_take |=> mst_rvalid)
    else $error("access not answered");
  a_end_refused: assert property (mst_valid && frame_end |=> mst_denied)
    else $error("frame end access not refused");
  a_mst_cause: assert property (mst_rvalid |-> $past(mst_valid))
    else $error("answer without access");
  a_mst_deny: assert property (mst_denied |-> mst_rvalid && mst_rdata == 8'h00)
    else $error("refused access returned data");
  a_hst_deny: assert property (hst_denied |-> hst_rvalid && hst_rdata == 8'h00)
    else $error("refused host access returned data");
  // the fieldbus side wins: no host answer right after its busy cycles
  a_host_yields: assert property (mst_valid |=> !hst_rvalid)
    else $error("host served beside fieldbus access");
  a_frame_yields: assert property (frame_end |=> !hst_rvalid)
    else $error("host served in frame end cycle");
  a_irq_passes: assert property ($past(resetn) |->
    (mst_irq_out & $past(mst_irq_in)) == $past(mst_irq_in))
    else $error("incoming irq bits lost");
endmodule : bcel_top_asserts

bind bcel_top bcel_top_asserts u_chk (.sys_clk, .resetn, .mst_valid,
  .frame_end, .mst_rvalid, .mst_rdata, .mst_denied, .mst_irq_in,
  .mst_irq_out, .hst_rvalid, .hst_rdata, .hst_denied);

// ### sim/buffer_channel_event_logic_tb.sv
// self-checking bench for the buffer channel and event block
`timescale 1ns/1ps
module buffer_channel_event_logic_tb;
  import bcel_pkg::*;
  logic         sys_clk = 1'h0, resetn = 1'h0, mst_valid = 1'h0;
  logic         frame_end = 1'h0, fcs_ok = 1'h0, mst_rvalid, mst_denied;
  logic         sync_pulse_zero = 1'h0, sync_pulse_one = 1'h0;
  logic         hst_valid, hst_ready, hst_rvalid, hst_denied;
  logic         irq_out, irq_oe_n;
  logic [7:0]   mst_rdata, hst_rdata, pat[2][4];
  logic [7:0]   ct[3] = '{8'h04, 8'h06, 8'h00};
  logic [15:0]  mst_irq_in = 16'h0000, mst_irq_out;
  bcel_req_type mst_req = '0, hst_req;
  logic [9:0]   rq[$];
  int           offs[6] = '{0, 1, 0, 2, 3, 3};
  int           n_fail = 0, total_checks = 0, cyc = 0;

  bcel_top dut (.sys_clk, .resetn, .mst_valid, .mst_req, .frame_end,
    .fcs_ok, .mst_rvalid, .mst_rdata, .mst_denied, .mst_irq_in,
    .mst_irq_out, .hst_valid, .hst_ready, .hst_req, .hst_rvalid,
    .hst_rdata, .hst_denied, .sync_pulse_zero, .sync_pulse_one,
    .irq_out, .irq_oe_n);
  bcel_host_model hm (.sys_clk, .hst_ready, .hst_valid, .hst_req);

  always #20 sys_clk = ~sys_clk;
  // host answers queue up in order; a hang is cut short
  always @(posedge sys_clk) begin
    cyc++;
    if (hst_rvalid === 1'h1) rq.push_back({1'h1, hst_denied, hst_rdata});
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one byte access from either side; e holds {refused, data}
  task automatic acc(input logic h, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [8:0] e = 9'h000);
    logic [9:0] r;
    int n;
    r = 10'h000;
    n = 0;
    if (h) begin
      hm.q.push_back(bcel_req_type'{w, a, d});
      while (rq.size() == 0 && n < 99) begin
        @(negedge sys_clk);
        n++;
      end
      if (rq.size() > 0) r = rq.pop_front();
    end else begin
      @(negedge sys_clk);
      mst_valid = 1'h1;
      mst_req = '{w, a, d};
      @(negedge sys_clk);
      mst_valid = 1'h0;
      mst_req = ~mst_req;
      r = {mst_rvalid, mst_denied, mst_rdata};
    end
    check(16'(r), {7'h01, e});
  endtask : acc

  // frame end pulse, then time for commit and interrupt to settle
  task automatic frame(input logic ok);
    @(negedge sys_clk);
    frame_end = 1'h1;
    fcs_ok = ok;
    @(negedge sys_clk);
    frame_end = 1'h0;
    repeat (3) @(negedge sys_clk);
  endtask : frame

  initial begin
    logic [15:0] b;
    int i, j, k;
    void'($urandom(50));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'h1;
    acc(0, 0, BCEL_OFF_MST_MASK, 8'h00);
    acc(0, 1, 16'h0201, 8'h04);
    acc(0, 0, 16'h0201, 8'h00, 9'h004);
    acc(1, 0, BCEL_OFF_HOST_INFO, 8'h00);
    acc(1, 0, 16'h2000, 8'h00, 9'h100);
    acc(1, 1, BCEL_OFF_SYNC_CFG, 8'h02);
    acc(1, 1, 16'h0205, 8'h01);
    // channels: buffered from fieldbus, mailbox, buffered from host
    for (i = 0; i < 3; i++) begin
      b = BCEL_CH_BASE + 16'(8 * i);
      acc(0, 1, b + 16'h1, 8'(8'h10 + i));
      acc(0, 1, b + 16'h2, 8'(4 >> i));
      acc(0, 1, b + 16'h4, ct[i]);
      acc(0, 1, b + 16'h6, 8'h01);
      acc(1, 0, b + 16'h4, 8'h00, {1'h0, ct[i]});
      acc(1, 0, b + 16'h6, 8'h00, 9'h001);
    end
    // late opening refused; reopened start; second end refused
    acc(1, 0, 16'h1001, 8'h00, 9'h100);
    for (j = 0; j < 2; j++) begin
      for (k = 0; k < 4; k++) pat[j][k] = 8'($urandom);
      for (k = 0; k < 6; k++)
        acc(0, 1, 16'h1000 + 16'(offs[k]), pat[j][offs[k]], {k == 5, 8'h00});
      frame(1'h1);
    end
    check({irq_oe_n, irq_out}, 16'h0001);
    for (k = 0; k < 4; k++)
      acc(1, 0, 16'h1000 + 16'(k), 8'h00, {1'h0, pat[1][k]});
    // a bad checksum leaves the consumer on the newest good buffer
    for (k = 0; k < 4; k++) acc(0, 1, 16'h1000 + 16'(k), ~pat[1][k]);
    frame(1'h0);
    check({irq_oe_n, irq_out}, 16'h0000);
    acc(1, 0, 16'h1000, 8'h00, {1'h0, pat[1][0]});
    // mailbox: producer locked out until the consumer read it all
    acc(0, 1, 16'h1100, pat[0][0]);
    acc(0, 1, 16'h1101, pat[0][1]);
    frame(1'h1);
    acc(0, 1, 16'h1100, 8'h00, 9'h100);
    frame(1'h1);
    acc(1, 0, 16'h1100, 8'h00, {1'h0, pat[0][0]});
    acc(1, 0, 16'h1101, 8'h00, {1'h0, pat[0][1]});
    acc(1, 0, 16'h1100, 8'h00, 9'h100);
    acc(0, 1, 16'h1100, 8'h00);
    // host completes a one-byte buffer; the fieldbus irq field shows it
    mst_irq_in = 16'($urandom) & 16'hFBFF;
    acc(1, 1, 16'h1200, pat[0][2]);
    @(negedge sys_clk);
    check(mst_irq_out, mst_irq_in | 16'h0400);
    acc(0, 0, 16'h1200, 8'h00, {1'h0, pat[0][2]});
    frame(1'h1);
    check(mst_irq_out, mst_irq_in);
    // sync pulses land in the host request only where mapped
    for (j = 0; j < 2; j++) begin
      acc(1, 1, BCEL_OFF_SYNC_CFG, j ? 8'h83 : 8'h0A);
      acc(1, 1, BCEL_OFF_HOST_MASK, 8'h0C);
      sync_pulse_zero = 1'h1;
      sync_pulse_one = 1'h1;
      @(negedge sys_clk);
      sync_pulse_zero = 1'h0;
      sync_pulse_one = 1'h0;
      repeat (3) @(negedge sys_clk);
      check({irq_oe_n, irq_out}, 16'h0001);
      acc(1, 0, BCEL_OFF_HOST_REQ, 8'h00, j ? 9'h008 : 9'h004);
      repeat (3) @(negedge sys_clk);
      check(16'(irq_oe_n), 16'(j));
    end
    // busy fieldbus: host requests fill the FIFO until it stops taking them
    mst_valid = 1'h1;
    mst_req = '{1'h0, BCEL_OFF_MST_MASK, 8'h00};
    repeat (10) hm.q.push_back(bcel_req_type'{1'h0, 16'h0205, 8'h00});
    repeat (20) @(negedge sys_clk);
    check({hst_ready, 8'(rq.size())}, 16'h0000);
    mst_valid = 1'h0;
    repeat (30) @(negedge sys_clk);
    check(16'(rq.size()), 16'h000A);
    while (rq.size() > 0) check(16'(rq.pop_front()), 16'h0201);
    summarize();
  end
endmodule : buffer_channel_event_logic_tb
